// ---- verilog/trx_regs_pkg.sv ----
package trx_regs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATE_READBACK = 8'h01;
    localparam logic [7:0] ADDR_CMD_RESULT     = 8'h02;
    localparam logic [7:0] ADDR_MP_CTRL        = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h11;
    localparam logic [7:0] ADDR_IRQ_CLEAR      = 8'h12;

    localparam logic [7:0] MP_CTRL_RESET       = 8'h20;
    localparam int         MP_AUTO_FCS_BIT     = 5;

    // ----------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------
    localparam logic [4:0] ST_POWER_ON         = 5'h00;
    localparam logic [4:0] ST_RECEIVING        = 5'h01;
    localparam logic [4:0] ST_TRANSMITTING     = 5'h02;
    localparam logic [4:0] ST_LISTEN           = 5'h06;
    localparam logic [4:0] ST_IDLE_CLOCKED     = 5'h08;
    localparam logic [4:0] ST_SYNTH_LOCKED     = 5'h09;
    localparam logic [4:0] ST_SLEEP            = 5'h0f;
    localparam logic [4:0] ST_AUTO_ACK_BUSY    = 5'h11;
    localparam logic [4:0] ST_AUTO_RETRY_BUSY  = 5'h12;
    localparam logic [4:0] ST_AUTO_ACK_LISTEN  = 5'h16;
    localparam logic [4:0] ST_AUTO_RETRY_READY = 5'h19;
    localparam logic [4:0] ST_UNCLK_LISTEN     = 5'h1c;
    localparam logic [4:0] ST_UNCLK_AACK_LISTEN = 5'h1d;
    localparam logic [4:0] ST_UNCLK_AACK_BUSY  = 5'h1e;
    localparam logic [4:0] ST_SWITCHING        = 5'h1f;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [4:0] CMD_NOP             = 5'h00;
    localparam logic [4:0] CMD_BEGIN_SEND      = 5'h02;
    localparam logic [4:0] CMD_FORCED_OFF      = 5'h03;
    localparam logic [4:0] CMD_FORCED_LOCK     = 5'h04;
    localparam logic [4:0] CMD_LISTEN          = 5'h06;
    localparam logic [4:0] CMD_IDLE_CLOCKED    = 5'h08;
    localparam logic [4:0] CMD_SYNTH_LOCKED    = 5'h09;
    localparam logic [4:0] CMD_AUTO_ACK_LISTEN = 5'h16;
    localparam logic [4:0] CMD_AUTO_RETRY_READY = 5'h19;

    // ----------------------------------------------------------------
    // Transaction result codes
    // ----------------------------------------------------------------
    localparam logic [2:0] RES_SUCCESS         = 3'h0;
    localparam logic [2:0] RES_PENDING         = 3'h1;
    localparam logic [2:0] RES_AWAIT_ACK       = 3'h2;
    localparam logic [2:0] RES_MEDIUM_BUSY     = 3'h3;
    localparam logic [2:0] RES_NO_ACK          = 3'h5;
    localparam logic [2:0] RES_INVALID         = 3'h7;

    // ----------------------------------------------------------------
    // Timing and event layout
    // ----------------------------------------------------------------
    localparam int         SWITCH_TIME_NS      = 200;
    localparam int         CLK_PERIOD_NS       = 20;
    localparam int         SWITCH_CYCLES       = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;
    localparam int         N_EVENTS            = 4;
    localparam int         EV_STATE_DONE       = 0;
    localparam int         EV_TXN_END          = 1;
    localparam int         EV_TXN_START        = 2;
    localparam int         EV_CMD_DROPPED      = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic       done;
        logic [2:0] code;
    } txn_report_s;

endpackage : trx_regs_pkg

// ---- verilog/reset_sync.sv ----
`timescale 1ns/1ps
module reset_sync
(
    // Clock and raw reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Released reset
    output logic      sync_rst_n
);
    logic stage;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage      <= 1'b0;
            sync_rst_n <= 1'b0;
        end
        else
        begin
            stage      <= 1'b1;
            sync_rst_n <= stage;
        end
    end
endmodule : reset_sync

// ---- verilog/sticky_events.sv ----
`timescale 1ns/1ps
module sticky_events
#(
    parameter int N = 4
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Events and software control
    input  wire logic [N-1:0] event_pulse,
    input  wire logic [N-1:0] clear_mask,
    input  wire logic         clear_wr,
    input  wire logic [N-1:0] enable_mask,
    // Results
    output logic [N-1:0]      status,
    output logic              irq
);
    // A new event in the clear cycle survives: set wins over clear.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= '0;
        else
            status <= (status & ~(clear_wr ? clear_mask : '0)) | event_pulse;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(((status & ~(clear_wr ? clear_mask : '0)) | event_pulse) & enable_mask);
    end
endmodule : sticky_events

// ---- verilog/transceiver_state_control_regs.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module transceiver_state_control_regs
(
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // Register port
    input  wire trx_regs_pkg::reg_req_s    req,
    output logic [7:0]                     rdata,
    // Radio core events
    input  wire logic                      sleep_request,
    input  wire logic                      wake_request,
    input  wire logic                      frame_rx_start,
    input  wire logic                      channel_check_done,
    input  wire logic                      channel_check_idle,
    input  wire trx_regs_pkg::txn_report_s txn_report,
    // Control outputs
    output logic [7:0]                     mp_control,
    output logic                           auto_fcs_enable,
    output logic [4:0]                     state_code,
    output logic                           irq
);
    import trx_regs_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_sync_n;

    reset_sync u_reset_sync
    (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .sync_rst_n (rst_sync_n)
    );

    // ----------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------
    logic       asleep;
    logic       wr_ok;
    logic       rd_ok;
    logic       cmd_wr;
    logic [4:0] target;
    logic [4:0] next_target;
    logic [4:0] cur_state;
    logic [4:0] hold_cnt;
    logic       switching;
    logic       cmd_accept;
    logic       cmd_drop;
    logic       txn_start;
    logic [2:0] result;
    logic       chk_done;
    logic       chk_idle;
    logic [N_EVENTS-1:0] ev_status;
    logic [N_EVENTS-1:0] ev_enable;
    logic [N_EVENTS-1:0] ev_pulse;
    logic       state_done;
    logic       in_auto_mode;

    assign asleep = (cur_state == ST_SLEEP);
    assign wr_ok  = req.wr && !asleep;
    assign rd_ok  = req.rd && !asleep;
    assign cmd_wr = wr_ok && (req.addr == ADDR_CMD_RESULT);

    // ----------------------------------------------------------------
    // Command interpretation
    // ----------------------------------------------------------------
    // Forced lock is refused from sleep, power-on, unclocked states and
    // from any switch heading toward them.
    function automatic logic lock_blocked(input logic [4:0] st);
        lock_blocked = (st == ST_SLEEP) || (st == ST_POWER_ON) ||
                       (st == ST_UNCLK_LISTEN) || (st == ST_UNCLK_AACK_LISTEN) ||
                       (st == ST_UNCLK_AACK_BUSY);
    endfunction : lock_blocked

    always_comb
    begin
        next_target = cur_state;
        cmd_accept  = 1'b0;
        case (req.wdata[4:0])
            CMD_BEGIN_SEND:
            begin
                cmd_accept  = !switching;
                next_target = (cur_state == ST_AUTO_RETRY_READY) ? ST_AUTO_RETRY_BUSY
                            : ST_TRANSMITTING;
            end
            CMD_FORCED_OFF:
            begin
                cmd_accept  = 1'b1;
                next_target = ST_IDLE_CLOCKED;
            end
            CMD_FORCED_LOCK:
            begin
                cmd_accept  = !lock_blocked(cur_state) &&
                              !(switching && lock_blocked(target));
                next_target = ST_SYNTH_LOCKED;
            end
            CMD_LISTEN, CMD_IDLE_CLOCKED, CMD_SYNTH_LOCKED,
            CMD_AUTO_ACK_LISTEN, CMD_AUTO_RETRY_READY:
            begin
                cmd_accept  = !switching;
                next_target = req.wdata[4:0];
            end
            default:
            begin
                cmd_accept  = 1'b0;
                next_target = cur_state;
            end
        endcase
    end

    assign cmd_drop  = cmd_wr && !cmd_accept &&
                       (req.wdata[4:0] != CMD_NOP) && (req.wdata[4:0] != CMD_FORCED_OFF);
    assign txn_start = cmd_wr && cmd_accept && (next_target == ST_AUTO_RETRY_BUSY);

    // ----------------------------------------------------------------
    // State tracking
    // ----------------------------------------------------------------
    // The switch lasts a fixed settle time; a radio core would replace it.
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cur_state <= ST_IDLE_CLOCKED;
            target    <= ST_IDLE_CLOCKED;
            hold_cnt  <= '0;
            switching <= 1'b0;
        end
        else if (asleep)
        begin
            if (wake_request)
            begin
                cur_state <= ST_SWITCHING;
                target    <= ST_IDLE_CLOCKED;
                hold_cnt  <= 5'(SWITCH_CYCLES);
                switching <= 1'b1;
            end
        end
        else if (sleep_request && !switching && cur_state == ST_IDLE_CLOCKED)
            cur_state <= ST_SLEEP;
        else if (cmd_wr && cmd_accept)
        begin
            if (next_target == ST_AUTO_RETRY_BUSY || next_target == ST_TRANSMITTING)
                cur_state <= next_target;
            else
            begin
                cur_state <= ST_SWITCHING;
                hold_cnt  <= 5'(SWITCH_CYCLES);
                switching <= 1'b1;
            end
            target <= next_target;
        end
        else if (switching)
        begin
            if (hold_cnt == 5'h01)
            begin
                cur_state <= target;
                switching <= 1'b0;
            end
            hold_cnt <= hold_cnt - 5'h01;
        end
        else if (cur_state == ST_AUTO_RETRY_BUSY && txn_report.done)
            cur_state <= ST_AUTO_RETRY_READY;
        else if (cur_state == ST_TRANSMITTING && txn_report.done)
            cur_state <= ST_SYNTH_LOCKED;
        else if (cur_state == ST_LISTEN && frame_rx_start)
            cur_state <= ST_RECEIVING;
        else if (cur_state == ST_RECEIVING && txn_report.done)
            cur_state <= ST_LISTEN;
    end

    assign state_done = switching && (hold_cnt == 5'h01) && !(cmd_wr && cmd_accept);

    // ----------------------------------------------------------------
    // Transaction result and channel flags
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            result <= RES_SUCCESS;
        else if (txn_start)
            result <= RES_INVALID;
        else if (cur_state == ST_AUTO_RETRY_BUSY && txn_report.done)
            result <= txn_report.code;
    end

    assign in_auto_mode = (cur_state == ST_AUTO_RETRY_BUSY) ||
                          (cur_state == ST_AUTO_RETRY_READY) ||
                          (cur_state == ST_AUTO_ACK_BUSY) ||
                          (cur_state == ST_AUTO_ACK_LISTEN);

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            chk_done <= 1'b0;
            chk_idle <= 1'b0;
        end
        else if (!in_auto_mode && channel_check_done)
        begin
            chk_done <= 1'b1;
            chk_idle <= channel_check_idle;
        end
    end

    // ----------------------------------------------------------------
    // Control register and interrupt enable
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            mp_control <= MP_CTRL_RESET;
        else if (wr_ok && req.addr == ADDR_MP_CTRL)
            mp_control <= req.wdata;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ev_enable <= '0;
        else if (wr_ok && req.addr == ADDR_IRQ_ENABLE)
            ev_enable <= req.wdata[N_EVENTS-1:0];
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            auto_fcs_enable <= 1'b1;
            state_code      <= ST_IDLE_CLOCKED;
        end
        else
        begin
            auto_fcs_enable <= mp_control[MP_AUTO_FCS_BIT];
            state_code      <= cur_state;
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    always_comb
    begin
        ev_pulse                 = '0;
        ev_pulse[EV_STATE_DONE]  = state_done;
        ev_pulse[EV_TXN_END]     = (cur_state == ST_AUTO_RETRY_BUSY) && txn_report.done;
        ev_pulse[EV_TXN_START]   = txn_start;
        ev_pulse[EV_CMD_DROPPED] = cmd_drop;
    end

    sticky_events #(.N(N_EVENTS)) u_events
    (
        .core_clk    (core_clk),
        .rst_n       (rst_sync_n),
        .event_pulse (ev_pulse),
        .clear_mask  (req.wdata[N_EVENTS-1:0]),
        .clear_wr    (wr_ok && req.addr == ADDR_IRQ_CLEAR),
        .enable_mask (ev_enable),
        .status      (ev_status),
        .irq         (irq)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Reads while asleep return zero; the port never stalls.
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rdata <= 8'h00;
        else if (!rd_ok)
            rdata <= 8'h00;
        else
        begin
            case (req.addr)
                ADDR_STATE_READBACK: rdata <= {chk_done, chk_idle, 1'b0, cur_state};
                ADDR_CMD_RESULT:     rdata <= {result, 5'h00};
                ADDR_MP_CTRL:        rdata <= mp_control;
                ADDR_IRQ_STATUS:     rdata <= {{(8-N_EVENTS){1'b0}}, ev_status};
                ADDR_IRQ_ENABLE:     rdata <= {{(8-N_EVENTS){1'b0}}, ev_enable};
                default:             rdata <= 8'h00;
            endcase
        end
    end
endmodule : transceiver_state_control_regs

// ---- verification/trx_regs_chk.sv ----
`timescale 1ns/1ps
module trx_regs_chk
(
    // Clock and reset
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    // Observed ports
    input wire trx_regs_pkg::reg_req_s    req,
    input wire logic [7:0]                rdata,
    input wire trx_regs_pkg::txn_report_s txn_report,
    input wire logic                      sleep_request,
    input wire logic [7:0]                mp_control,
    input wire logic                      auto_fcs_enable,
    input wire logic [4:0]                state_code
);
    import trx_regs_pkg::*;
    // ------
    // Checks
    // ------
    // The core leaves reset two edges after rst_n, so checks wait it out.
    logic [1:0] age;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n || age != 2'h3);
    sequence cmd_wr(logic [4:0] c);
        req.wr && req.addr == ADDR_CMD_RESULT && req.wdata[4:0] == c;
    endsequence
    fcs_follow_a : assert property (
        auto_fcs_enable == $past(mp_control[MP_AUTO_FCS_BIT]))
        else $error("checksum enable differs from control bit");
    rd_state_a : assert property (
        req.rd && req.addr == ADDR_STATE_READBACK |=>
        state_code == ST_SLEEP || (rdata[4:0] == state_code && !rdata[5]))
        else $error("status read differs from state code");
    sleep_rd_a : assert property (
        req.rd ##1 state_code == ST_SLEEP |-> rdata == 8'h00)
        else $error("register readable while asleep");
    send_start_a : assert property (
        cmd_wr(CMD_BEGIN_SEND) ##1 state_code == ST_AUTO_RETRY_READY
        |=> state_code == ST_AUTO_RETRY_BUSY)
        else $error("begin send did not go busy");
    switch_start_a : assert property (
        cmd_wr(CMD_LISTEN) ##1 state_code == ST_IDLE_CLOCKED
        |=> state_code == ST_SWITCHING)
        else $error("command did not start a switch");
    switch_end_a : assert property (
        state_code == ST_SWITCHING |-> ##[1:20] state_code != ST_SWITCHING)
        else $error("switch never ends");
    busy_hold_a : assert property (
        state_code == ST_AUTO_RETRY_BUSY && !$past(txn_report.done) && !$past(req.wr)
        |=> state_code == ST_AUTO_RETRY_BUSY)
        else $error("busy left before transaction end");
    busy_end_a : assert property (
        txn_report.done ##1 state_code == ST_AUTO_RETRY_BUSY
        |=> state_code == ST_AUTO_RETRY_READY)
        else $error("no return to ready after transaction");
    nop_cmd_a : assert property (
        req.wr && req.addr == ADDR_CMD_RESULT && req.wdata[4:0] inside {[5'h0a:5'h15]}
        && !sleep_request ##1 state_code == ST_IDLE_CLOCKED
        |=> state_code == ST_IDLE_CLOCKED)
        else $error("reserved command changed state");
    cover property (txn_report.done ##1 state_code == ST_AUTO_RETRY_BUSY);
    cover property (state_code == ST_SLEEP);
    cover property (state_code == ST_SWITCHING);
endmodule : trx_regs_chk

// ---- verification/trx_host_model.sv ----
`timescale 1ns/1ps
module trx_host_model
(
    // Clock
    input wire logic               core_clk,
    // Register port
    output trx_regs_pkg::reg_req_s req,
    input wire logic [7:0]         rdata
);
    import trx_regs_pkg::*;
    // ----------
    // Bus cycles
    // ----------
    initial
    begin
        req = '0;
    end
    // Released lines are inverted so that a stale value never looks valid.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: req.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: ~req.wdata, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata;
    endtask : read_reg
    task automatic settle(output logic [7:0] s);
        int n;
        n = 0;
        s = 8'h1f;
        while (s[4:0] == ST_SWITCHING && n < 40)
        begin
            read_reg(ADDR_STATE_READBACK, s);
            n++;
        end
    endtask : settle
    task automatic command(input logic [4:0] c, output logic [7:0] s);
        settle(s);
        if (!(c == CMD_FORCED_LOCK && s[4:0] inside {ST_SLEEP, ST_POWER_ON, [5'h1c:5'h1e]}))
            write_reg(ADDR_CMD_RESULT, {3'h0, c});
        settle(s);
    endtask : command
endmodule : trx_host_model

// ---- verification/transceiver_state_control_regs_bench.sv ----
`timescale 1ns/1ps
`define CHECK(w, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("wrong value %s expected %h seen %h", w, e, g); \
        end \
    end
module transceiver_state_control_regs_bench;
    import trx_regs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n, sleep_request, wake_request, channel_check_done, channel_check_idle;
    logic auto_fcs_enable, irq;
    logic [7:0] rdata, mp_control;
    logic [4:0] state_code;
    reg_req_s req;
    txn_report_s txn_report;
    int miscompares = 0;
    int n_compared = 0;
    int exp_state, exp_result, exp_mp, exp_flags, exp_ev, exp_en;
    int codes[$] = '{0, 1, 3, 5};
    int cmds[$] = '{CMD_FORCED_OFF, CMD_FORCED_LOCK, CMD_LISTEN, CMD_AUTO_ACK_LISTEN,
                    CMD_SYNTH_LOCKED, CMD_IDLE_CLOCKED, CMD_AUTO_RETRY_READY, CMD_NOP};
    int dests[$] = '{ST_IDLE_CLOCKED, ST_SYNTH_LOCKED, ST_LISTEN, ST_AUTO_ACK_LISTEN,
                     ST_SYNTH_LOCKED, ST_IDLE_CLOCKED, ST_AUTO_RETRY_READY, ST_AUTO_RETRY_READY};
    transceiver_state_control_regs uut
    (
        .core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .sleep_request(sleep_request), .wake_request(wake_request), .frame_rx_start(1'b0),
        .channel_check_done(channel_check_done), .channel_check_idle(channel_check_idle),
        .txn_report(txn_report), .mp_control(mp_control), .auto_fcs_enable(auto_fcs_enable),
        .state_code(state_code), .irq(irq)
    );
    trx_host_model host (.core_clk(core_clk), .req(req), .rdata(rdata));
    always #10 core_clk = ~core_clk;
    // -----
    // Tasks
    // -----
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic check_all();
        logic [7:0] v;
        host.read_reg(ADDR_STATE_READBACK, v);
        `CHECK("status", 8'((exp_flags << 6) | exp_state), v)
        host.read_reg(ADDR_CMD_RESULT, v);
        `CHECK("result", 8'(exp_result << 5), v)
        host.read_reg(ADDR_MP_CTRL, v);
        `CHECK("control", 8'(exp_mp), v)
        `CHECK("control port", 8'(exp_mp), mp_control)
        `CHECK("checksum enable", 1'(exp_mp >> 5), auto_fcs_enable)
        host.read_reg(ADDR_IRQ_ENABLE, v);
        `CHECK("enable", 8'(exp_en), v)
        host.read_reg(ADDR_IRQ_STATUS, v);
        `CHECK("events", 8'(exp_ev), v)
        `CHECK("irq", (exp_ev & exp_en) != 0, irq)
    endtask : check_all
    task automatic clear_events();
        host.write_reg(ADDR_IRQ_CLEAR, 8'h0f);
        exp_ev = 0;
    endtask : clear_events
    task automatic pulse_check(input logic idle);
        @(posedge core_clk);
        channel_check_done <= 1'b1;
        channel_check_idle <= idle;
        @(posedge core_clk);
        channel_check_done <= 1'b0;
    endtask : pulse_check
    task automatic end_txn(input logic [2:0] c);
        @(posedge core_clk);
        txn_report <= '{done: 1'b1, code: c};
        @(posedge core_clk);
        txn_report <= '{done: 1'b0, code: ~c};
    endtask : end_txn
    task automatic wait_state(input logic [4:0] s);
        int n;
        n = 0;
        while (state_code !== s && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHECK("state port", s, state_code)
    endtask : wait_state
    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end
    initial
    begin
        logic [7:0] v;
        void'($urandom(39473));
        rst_n = 1'b0;
        sleep_request = 1'b0;
        wake_request = 1'b0;
        channel_check_done = 1'b0;
        channel_check_idle = 1'b0;
        txn_report = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        exp_state = ST_IDLE_CLOCKED;
        exp_result = 0;
        exp_mp = MP_CTRL_RESET;
        exp_flags = 0;
        exp_ev = 0;
        exp_en = 0;
        check_all();
        repeat (3)
        begin
            exp_mp = $urandom_range(0, 255);
            host.write_reg(ADDR_MP_CTRL, 8'(exp_mp));
            check_all();
        end
        host.read_reg(8'h07, v);
        `CHECK("unmapped", 8'h00, v)
        exp_en = $urandom_range(0, 15) | 9;
        host.write_reg(ADDR_IRQ_ENABLE, 8'(exp_en));
        repeat (3)
        begin
            host.write_reg(ADDR_CMD_RESULT, {3'h7, 5'($urandom_range(10, 21))});
            // A reserved code leaves the state alone but is still reported as refused.
            exp_ev |= 8;
            check_all();
        end
        pulse_check(1'b1);
        exp_flags = 3;
        // A command sent mid-switch is refused and must not disturb the switch.
        host.write_reg(ADDR_CMD_RESULT, {3'h0, CMD_LISTEN});
        host.write_reg(ADDR_CMD_RESULT, {3'h0, CMD_SYNTH_LOCKED});
        host.read_reg(ADDR_STATE_READBACK, v);
        `CHECK("switching", 8'(ST_SWITCHING | 8'hc0), v)
        host.settle(v);
        exp_state = ST_LISTEN;
        exp_ev = 9;
        check_all();
        host.write_reg(ADDR_IRQ_ENABLE, 8'h00);
        exp_en = 0;
        check_all();
        clear_events();
        exp_en = 15;
        host.write_reg(ADDR_IRQ_ENABLE, 8'h0f);
        foreach (cmds[i])
        begin
            host.command(5'(cmds[i]), v);
            exp_state = dests[i];
            clear_events();
            check_all();
        end
        pulse_check(1'b0);
        check_all();
        foreach (codes[i])
        begin
            host.write_reg(ADDR_CMD_RESULT, {3'h0, CMD_BEGIN_SEND});
            exp_state = ST_AUTO_RETRY_BUSY;
            exp_result = RES_INVALID;
            exp_ev |= 4;
            check_all();
            end_txn(3'(codes[i]));
            exp_state = ST_AUTO_RETRY_READY;
            exp_result = codes[i];
            exp_ev |= 2;
            check_all();
        end
        host.command(CMD_IDLE_CLOCKED, v);
        @(posedge core_clk);
        sleep_request <= 1'b1;
        wait_state(ST_SLEEP);
        @(posedge core_clk);
        sleep_request <= 1'b0;
        host.read_reg(ADDR_MP_CTRL, v);
        `CHECK("asleep read", 8'h00, v)
        host.write_reg(ADDR_MP_CTRL, 8'(~exp_mp));
        host.write_reg(ADDR_CMD_RESULT, {3'h0, CMD_FORCED_LOCK});
        wait_state(ST_SLEEP);
        @(posedge core_clk);
        wake_request <= 1'b1;
        wait_state(ST_IDLE_CLOCKED);
        @(posedge core_clk);
        wake_request <= 1'b0;
        exp_state = ST_IDLE_CLOCKED;
        clear_events();
        check_all();
        conclude();
    end
endmodule : transceiver_state_control_regs_bench
bind transceiver_state_control_regs trx_regs_chk chk
(
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .txn_report(txn_report),
    .sleep_request(sleep_request), .mp_control(mp_control),
    .auto_fcs_enable(auto_fcs_enable), .state_code(state_code)
);
